// ===== rtl/mlp_pkg.sv
// Purpose: Shared constants and carriers for the multi-lane pad configuration
// Assumes: One instance per serial master, three masters in the system
// Notes:   Mask bits 0..7 data pads, 8 clock pad, 9 data mask pad
package mlp_pkg;
	// Lane configuration codes
	localparam logic [3:0] one_lane_cs0   = 4'h1;
	localparam logic [3:0] one_lane_cs1   = 4'h2;
	localparam logic [3:0] two_lane_cs0   = 4'h5;
	localparam logic [3:0] two_lane_cs1   = 4'h6;
	localparam logic [3:0] four_lane_cs0  = 4'h9;
	localparam logic [3:0] four_lane_cs1  = 4'ha;
	localparam logic [3:0] eight_lane_cs0 = 4'hd;
	localparam logic [3:0] eight_lane_cs1 = 4'he;
	// Mixed phase codes
	localparam logic [2:0] uniform_width       = 3'h0;
	localparam logic [2:0] two_lane_data_only  = 3'h1;
	localparam logic [2:0] two_lane_addr_data  = 3'h3;
	localparam logic [2:0] four_lane_data_only = 3'h5;
	localparam logic [2:0] four_lane_addr_data = 3'h7;
	// Width as log2 of active lanes
	localparam logic [1:0] width_one   = 2'h0;
	localparam logic [1:0] width_two   = 2'h1;
	localparam logic [1:0] width_four  = 2'h2;
	localparam logic [1:0] width_eight = 2'h3;
	// Transfer phases
	localparam logic [1:0] phase_instr = 2'h0;
	localparam logic [1:0] phase_addr  = 2'h1;
	localparam logic [1:0] phase_data  = 2'h2;
	// Mask layout and expected masks
	localparam int         mask_clock_bit = 8;
	localparam int         mask_dm_bit    = 9;
	localparam logic [9:0] mask_one_sep   = 10'h103;
	localparam logic [9:0] mask_one       = 10'h101;
	localparam logic [9:0] mask_four      = 10'h10f;
	localparam logic [9:0] mask_four_alt  = 10'h1f0;
	localparam logic [9:0] mask_eight     = 10'h3ff;
	// Chip enable levels
	localparam logic [1:0] ce_idle = 2'h3;

	typedef struct packed {
		logic [3:0] lane_config_code;
		logic       separate_io_select;
		logic [2:0] mixed_phase_width;
		logic [9:0] pad_output_enable_mask;
	} mlp_cfg_t;

	typedef struct packed {
		logic       active;
		logic [1:0] phase;
		logic       rx;
		logic       auto_xfer;
	} mlp_xfer_t;

	typedef struct packed {
		logic [7:0] data;
		logic       data_mask;
	} mlp_lanes_t;
endpackage

// ===== rtl/mlp_pad_config.sv
// Purpose: Lane width, chip enable, pad enable and receive routing
// Assumes: Config and transfer inputs on i_clock, pad inputs asynchronous
// Notes:   All outputs registered, pad inputs pass two flops first
//
// Contract
// R1: Each master supports one, two, four or eight lanes with a clock and exactly one of two CEs.
// R2: Configurations pair a lane width with CE0 or CE1 and the clock pad is driven in every one.
// R3: Serial uses lane 0 as output and lane 1 as input; wider modes make active lanes and octal mask two-way.
// R4: Without separate IO a serial read returns on lane 0, so lane 0 is released while receiving.
// R5: With separate IO set, receive input 0 takes pad lane 1, otherwise pad lane 0.
// R6: Codes 1,2,5,6,9,0xA,0xD,0xE select serial, dual, quad, octal with CE0 or CE1.
// R7: Mixed codes 0,1,3,5,7 give uniform, dual data, dual addr+data, quad data, quad addr+data.
// R8: The output enable mask must match the mode: 0x103, 0x101, 0x10F (or 0x1F0), 0x3FF; the code accepts 0x1F0 only with code 0xA.
// R9: Data pad 4 of any master is never used as a clock line.
// R10: With a nonzero mixed code the instruction goes at base width and later phases widen for auto transfers.
// R11: Mask bits 0-7 gate data pads, bit 8 the clock, bit 9 the mask pad, together with the lane role.
// R12: Both CEs stay high except the selected one during an active transfer.
`timescale 1ns/1ps
module mlp_pad_config (
	// Clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_resetn,
	// Configuration
	input  wire mlp_pkg::mlp_cfg_t  i_cfg,
	// Transfer state from the sequencer
	input  wire mlp_pkg::mlp_xfer_t i_xfer,
	input  wire logic               i_sclk,
	input  wire mlp_pkg::mlp_lanes_t i_tx,
	// Receive data to the sequencer
	output mlp_pkg::mlp_lanes_t     o_rx,
	// Pads
	input  wire mlp_pkg::mlp_lanes_t i_pad_in,
	output mlp_pkg::mlp_lanes_t     o_pad_out,
	output mlp_pkg::mlp_lanes_t     o_pad_oe_n,
	output logic                    o_pad_clk,
	output logic                    o_pad_clk_oe_n,
	output logic [1:0]              o_ce_n,
	// Status
	output logic [1:0]              o_lane_width,
	output logic                    o_cfg_error
);

	logic                cfg_valid;
	logic                cs_sel;
	logic [1:0]          base_w;
	logic                mix_valid;
	logic                mix_addr;
	logic [1:0]          mix_w;
	logic [1:0]          next_w;
	logic [9:0]          exp_mask;
	logic                mask_ok;
	logic [7:0]          next_data_oe_n;
	logic                next_dm_oe_n;
	mlp_pkg::mlp_lanes_t sync1;
	mlp_pkg::mlp_lanes_t sync2;

	// Lane code decode
	always_comb begin
		cfg_valid = 1'b1;
		cs_sel    = 1'b0;
		base_w    = mlp_pkg::width_one;
		unique case (i_cfg.lane_config_code) // [R6] [R1]
			mlp_pkg::one_lane_cs0: begin
				base_w = mlp_pkg::width_one;
			end
			mlp_pkg::one_lane_cs1: begin
				base_w = mlp_pkg::width_one;
				cs_sel = 1'b1;
			end
			mlp_pkg::two_lane_cs0: begin
				base_w = mlp_pkg::width_two;
			end
			mlp_pkg::two_lane_cs1: begin
				base_w = mlp_pkg::width_two;
				cs_sel = 1'b1;
			end
			mlp_pkg::four_lane_cs0: begin
				base_w = mlp_pkg::width_four;
			end
			mlp_pkg::four_lane_cs1: begin
				base_w = mlp_pkg::width_four;
				cs_sel = 1'b1;
			end
			mlp_pkg::eight_lane_cs0: begin
				base_w = mlp_pkg::width_eight;
			end
			mlp_pkg::eight_lane_cs1: begin
				base_w = mlp_pkg::width_eight;
				cs_sel = 1'b1;
			end
			default: begin
				cfg_valid = 1'b0;
			end
		endcase
	end

	// Mixed phase decode
	always_comb begin
		mix_valid = 1'b1;
		mix_addr  = 1'b0;
		mix_w     = mlp_pkg::width_one;
		unique case (i_cfg.mixed_phase_width) // [R7]
			mlp_pkg::uniform_width: begin
				mix_w = base_w;
			end
			mlp_pkg::two_lane_data_only: begin
				mix_w = mlp_pkg::width_two;
			end
			mlp_pkg::two_lane_addr_data: begin
				mix_w    = mlp_pkg::width_two;
				mix_addr = 1'b1;
			end
			mlp_pkg::four_lane_data_only: begin
				mix_w = mlp_pkg::width_four;
			end
			mlp_pkg::four_lane_addr_data: begin
				mix_w    = mlp_pkg::width_four;
				mix_addr = 1'b1;
			end
			default: begin
				mix_valid = 1'b0;
				mix_w     = base_w;
			end
		endcase
	end

	// Width per phase
	always_comb begin
		next_w = base_w;
		if (i_xfer.auto_xfer && i_cfg.mixed_phase_width != mlp_pkg::uniform_width) begin
			if (i_xfer.phase == mlp_pkg::phase_data) begin
				next_w = mix_w; // [R10]
			end else if (i_xfer.phase == mlp_pkg::phase_addr && mix_addr) begin
				next_w = mix_w; // [R10]
			end
		end
	end

	// Expected mask for the chosen mode
	always_comb begin
		exp_mask = mlp_pkg::mask_one;
		if (next_w == mlp_pkg::width_eight || base_w == mlp_pkg::width_eight) begin
			exp_mask = mlp_pkg::mask_eight;
		end else if (base_w == mlp_pkg::width_four || mix_w == mlp_pkg::width_four) begin
			exp_mask = mlp_pkg::mask_four;
		end else if (base_w == mlp_pkg::width_two || mix_w == mlp_pkg::width_two) begin
			exp_mask = mlp_pkg::mask_one_sep;
		end else if (i_cfg.separate_io_select) begin
			exp_mask = mlp_pkg::mask_one_sep;
		end
		mask_ok = (i_cfg.pad_output_enable_mask == exp_mask)
			|| (i_cfg.lane_config_code == mlp_pkg::four_lane_cs1
			&& i_cfg.pad_output_enable_mask == mlp_pkg::mask_four_alt); // [R8]
	end

	// Data pad roles
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_lane
			localparam logic [1:0] need_w = (g < 2) ? mlp_pkg::width_two
				: (g < 4) ? mlp_pkg::width_four : mlp_pkg::width_eight;
			logic role;
			always_comb begin
				role = 1'b0;
				if (next_w == mlp_pkg::width_one) begin
					// Lane 0 out, lane 1 in; lane 0 freed on a shared read
					role = (g == 0) && (!i_xfer.rx || i_cfg.separate_io_select); // [R3] [R4]
				end else begin
					role = (next_w >= need_w) && !i_xfer.rx; // [R3]
				end
			end
			assign next_data_oe_n[g] = !(role && i_xfer.active && cfg_valid
				&& i_cfg.pad_output_enable_mask[g]); // [R11]
		end
	endgenerate

	assign next_dm_oe_n = !(next_w == mlp_pkg::width_eight && i_xfer.active
		&& !i_xfer.rx && cfg_valid
		&& i_cfg.pad_output_enable_mask[mlp_pkg::mask_dm_bit]); // [R3] [R11]

	// Pad input synchroniser
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= i_pad_in;
			sync2 <= sync1;
		end
	end

	// Receive routing
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rx <= '0;
		end else begin
			o_rx           <= sync2;
			o_rx.data[0]   <= i_cfg.separate_io_select ? sync2.data[1] : sync2.data[0]; // [R5]
		end
	end

	// Pad drive
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pad_out      <= '0;
			o_pad_oe_n     <= '1;
			o_pad_clk      <= 1'b0;
			o_pad_clk_oe_n <= 1'b1;
		end else begin
			o_pad_out       <= i_tx;
			o_pad_oe_n.data <= next_data_oe_n;
			o_pad_oe_n.data_mask <= next_dm_oe_n;
			o_pad_clk       <= i_sclk;
			o_pad_clk_oe_n  <= !(cfg_valid
				&& i_cfg.pad_output_enable_mask[mlp_pkg::mask_clock_bit]); // [R2] [R11]
		end
	end

	// Chip enables
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ce_n <= mlp_pkg::ce_idle;
		end else if (i_xfer.active && cfg_valid) begin
			o_ce_n <= cs_sel ? 2'h1 : 2'h2; // [R12] [R1]
		end else begin
			o_ce_n <= mlp_pkg::ce_idle; // [R12]
		end
	end

	// Status
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_lane_width <= mlp_pkg::width_one;
			o_cfg_error  <= 1'b0;
		end else begin
			o_lane_width <= next_w;
			o_cfg_error  <= !(cfg_valid && mix_valid && mask_ok); // [R8]
		end
	end

	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence s_sep_held;
		i_cfg.separate_io_select [*3];
	endsequence

	sequence s_mixed_data;
		i_xfer.active && i_xfer.auto_xfer && i_xfer.phase == mlp_pkg::phase_data
			&& i_cfg.lane_config_code == mlp_pkg::one_lane_cs0
			&& i_cfg.mixed_phase_width == mlp_pkg::four_lane_data_only;
	endsequence

	a_ce_idle_high: assert property (!i_xfer.active |=> o_ce_n == 2'h3) // [R12]
		else $error("CE active outside a transfer");
	a_ce_single_one: assert property (o_ce_n != 2'h0) // [R1]
		else $error("Both chip enables active");
	a_clock_pad_on: assert property (cfg_valid && i_cfg.pad_output_enable_mask[8]
		|=> !o_pad_clk_oe_n) // [R2]
		else $error("Clock pad not driven");
	a_serial_lane_in: assert property (next_w == mlp_pkg::width_one
		|=> o_pad_oe_n.data[1] && o_pad_oe_n.data[7]) // [R3]
		else $error("Serial input lane driven");
	a_shared_read_free: assert property (next_w == mlp_pkg::width_one && i_xfer.rx
		&& !i_cfg.separate_io_select |=> o_pad_oe_n.data[0]) // [R4]
		else $error("Lane 0 driven during shared read");
	a_sep_io_route: assert property (s_sep_held |=> o_rx.data[0] == $past(i_pad_in.data[1], 3)) // [R5]
		else $error("Receive input 0 not from lane 1");
	a_octal_cs1_decode: assert property (i_xfer.active
		&& i_cfg.lane_config_code == mlp_pkg::eight_lane_cs1 && !i_xfer.auto_xfer
		|=> o_ce_n == 2'h1 && o_lane_width == 2'h3) // [R6]
		else $error("Octal CE1 decode wrong");
	a_mixed_quad_data: assert property (s_mixed_data |=> o_lane_width == 2'h2) // [R7]
		else $error("Quad data phase not widened");
	a_mixed_instr_base: assert property (i_xfer.phase == mlp_pkg::phase_instr
		&& i_cfg.lane_config_code == mlp_pkg::one_lane_cs1 |=> o_lane_width == 2'h0) // [R10]
		else $error("Instruction not at base width");
	a_octal_mask_ok: assert property (i_cfg.lane_config_code == mlp_pkg::eight_lane_cs0
		&& i_cfg.mixed_phase_width == 3'h0 && i_cfg.pad_output_enable_mask == 10'h3ff
		|=> !o_cfg_error) // [R8]
		else $error("Octal mask flagged");
	a_mask_gates_pad: assert property (!i_cfg.pad_output_enable_mask[2]
		|=> o_pad_oe_n.data[2]) // [R11]
		else $error("Masked pad driven");

endmodule

// ===== test/mlp_mem_model.sv
// Purpose: Behavioural external serial memory on the pads
// Assumes: Replies on every lane the master leaves released
// Notes:   Released lanes of an unselected device toggle each cycle
`timescale 1ns/1ps
module mlp_mem_model (
	// Clock and selection
	input  wire logic                i_clock,
	input  wire logic [1:0]          i_ce_n,
	input  wire logic                i_ce_sel,
	// Pads
	input  wire mlp_pkg::mlp_lanes_t i_out,
	input  wire mlp_pkg::mlp_lanes_t i_oe_n,
	input  wire mlp_pkg::mlp_lanes_t i_reply,
	output mlp_pkg::mlp_lanes_t      o_level
);
	logic [8:0] idle = 9'h0aa;
	always_ff @(posedge i_clock) begin
		idle <= ~idle;
	end
	// Master wins where it drives, else the selected device answers
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			o_level[i] = !i_oe_n[i] ? i_out[i] : !i_ce_n[i_ce_sel] ? i_reply[i] : idle[i];
		end
	end
endmodule

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the pad configuration block
// Assumes: Inputs change at the falling edge, outputs one cycle late
// Notes:   Random mix with code sweeps, receive routing and resets
`timescale 1ns/1ps
module tb_top;
	logic                clk  = 0;
	logic                rstn = 0;
	logic                sclk = 0;
	mlp_pkg::mlp_cfg_t   cfg  = '0;
	mlp_pkg::mlp_xfer_t  xf   = '0;
	mlp_pkg::mlp_lanes_t tx   = '0;
	mlp_pkg::mlp_lanes_t rply = '0;
	mlp_pkg::mlp_lanes_t lvl, rx, pout, oen;
	logic                pclk, pclk_oe_n, err;
	logic [1:0]          ce_n, wd;
	int                  n_fail = 0;
	int                  checks_done = 0;

	always #50 clk = ~clk;

	mlp_pad_config mlp_pad_config_i (.i_clock(clk), .i_resetn(rstn), .i_cfg(cfg),
		.i_xfer(xf), .i_sclk(sclk), .i_tx(tx), .o_rx(rx), .i_pad_in(lvl),
		.o_pad_out(pout), .o_pad_oe_n(oen), .o_pad_clk(pclk),
		.o_pad_clk_oe_n(pclk_oe_n), .o_ce_n(ce_n), .o_lane_width(wd), .o_cfg_error(err));
	// Clock stays on its own pad, lane 4 carries data only
	mlp_mem_model mlp_mem_model_i (.i_clock(clk), .i_ce_n(ce_n),
		.i_ce_sel(cfg.lane_config_code[1]), .i_out(pout), .i_oe_n(oen),
		.i_reply(rply), .o_level(lvl));

	task cmp(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task conclude();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	function automatic logic [1:0] ew();
		logic [2:0] m;
		m = cfg.mixed_phase_width;
		ew = cfg.lane_config_code[3:2];
		if (xf.auto_xfer && m[0] && (xf.phase == mlp_pkg::phase_data
			|| xf.phase == mlp_pkg::phase_addr && m[1])) ew = m[2] ? 2'h2 : 2'h1;
	endfunction

	function automatic logic [9:0] em();
		logic [1:0] b;
		logic [2:0] m;
		b = cfg.lane_config_code[3:2];
		m = cfg.mixed_phase_width;
		if (b == 2'h3) return mlp_pkg::mask_eight;
		if (b == 2'h2 || m[2] && m[0]) return mlp_pkg::mask_four;
		if (b == 2'h1 || m[0] || cfg.separate_io_select) return mlp_pkg::mask_one_sep;
		return mlp_pkg::mask_one;
	endfunction

	task chk_all();
		logic       cv;
		logic       ok;
		logic [2:0] m;
		logic [1:0] w;
		logic [8:0] d;
		logic [9:0] k;
		cv = ^cfg.lane_config_code[1:0];
		m = cfg.mixed_phase_width;
		k = cfg.pad_output_enable_mask;
		w = ew();
		for (int i = 0; i < 8; i++)
			d[i+1] = cv && xf.active && k[i] && (w == 0 ?
				i == 0 && (!xf.rx || cfg.separate_io_select) : i < (1 << w) && !xf.rx);
		d[0] = cv && xf.active && !xf.rx && w == 3 && k[9];
		ok = k == em() || cfg.lane_config_code == mlp_pkg::four_lane_cs1 && k == 10'h1f0;
		cmp("pad_oe_n", {1'b0, ~d}, oen);
		cmp("ce_n", cv && xf.active ? (cfg.lane_config_code[1] ? 2'h1 : 2'h2) : 2'h3, ce_n);
		cmp("clk_oe_n", !(cv && k[8]), pclk_oe_n);
		cmp("cfg_error", !cv || !(m == 0 || m[0]) || !ok, err);
		if (cv) cmp("width", w, wd);
		cmp("pad_out", tx, pout);
		cmp("pad_clk", sclk, pclk);
	endtask

	task put(input logic [3:0] c, input logic [2:0] m, input logic s, input logic [4:0] x);
		cfg = '{c, s, m, 10'h0};
		cfg.pad_output_enable_mask = em();
		xf = x;
		tx = 9'($urandom);
		sclk = 1'($urandom);
		rply = 9'($urandom);
	endtask

	task step();
		@(posedge clk);
		@(negedge clk);
		chk_all();
	endtask

	task rst_chk();
		rstn = 0;
		@(negedge clk);
		cmp("rst_oe_n", 10'h1ff, oen);
		cmp("rst_ce_n", 2'h3, ce_n);
		cmp("rst_misc", 10'h10, {pclk_oe_n, err, pclk, wd});
		cmp("rst_pad_out", 10'h0, pout);
		cmp("rst_rx", 10'h0, rx);
		@(negedge clk);
		rstn = 1;
		$display("test reset done");
	endtask

	initial begin
		#3000000;
		n_fail++;
		conclude();
	end

	initial begin
		void'($urandom(32'haee3));
		rst_chk();
		for (int c = 0; c < 16; c++) begin
			put(4'(c), 3'h0, 1'b0, {1'b1, 2'h2, 2'h0});
			step();
		end
		$display("test codes done");
		for (int m = 1; m < 8; m += 2)
			for (int p = 0; p < 3; p++) begin
				put(mlp_pkg::one_lane_cs0, 3'(m), 1'b0, {1'b1, 2'(p), 2'h1});
				step();
			end
		$display("test mixed done");
		for (int s = 0; s < 2; s++) begin
			put(mlp_pkg::one_lane_cs0, 3'h0, 1'(s), {1'b1, 2'h2, 2'h2});
			repeat (5) @(negedge clk);
			cmp("rx0", s ? rply.data[1] : rply.data[0], rx.data[0]);
			cmp("rx_hi", rply.data[7:1], rx.data[7:1]);
			cmp("rx_dm", rply.data_mask, rx.data_mask);
		end
		$display("test routing done");
		for (int n = 0; n < 300; n++) begin
			put(4'($urandom), 3'($urandom), 1'($urandom), {1'($urandom), 2'($urandom % 3), 2'($urandom)});
			if ($urandom % 4) cfg.lane_config_code[1:0] = $urandom % 2 ? 2'h1 : 2'h2;
			if ($urandom % 4) cfg.mixed_phase_width[0] = 1'b1;
			if ($urandom % 4) cfg.pad_output_enable_mask = em();
			else cfg.pad_output_enable_mask = 10'($urandom);
			step();
		end
		$display("test random done");
		rst_chk();
		put(mlp_pkg::eight_lane_cs1, 3'h0, 1'b0, {1'b1, 2'h2, 2'h0});
		step();
		$display("test octal done");
		conclude();
	end
endmodule
